// ==== pad_sleep_hold_map.vh ====
// constants for the pad sleep and hold controller
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`ifndef PAD_SLEEP_HOLD_MAP_VH
`define PAD_SLEEP_HOLD_MAP_VH

// ---------------------------------------------------------------------------
// pin positions
// ---------------------------------------------------------------------------
`define PROC_CLK_PIN 9
`define TIMER_CLK_PIN 10
`define SMARTCARD_PIN_A 114
`define SMARTCARD_PIN_B 115

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define HOLD_RESET_VAL 1'b1
`define SYNC_RESET_VAL 1'b1

// ---------------------------------------------------------------------------
// power-up sequencing times and cycle counts
// ---------------------------------------------------------------------------
`define CLK_MHZ 20
`define SYS_TO_PWR_NS 1000
`define PWR_TO_RUN_NS 2000
`define SYS_TO_PWR_CYC ((`SYS_TO_PWR_NS * `CLK_MHZ + 999) / 1000)
`define PWR_TO_RUN_CYC ((`PWR_TO_RUN_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== pad_sleep_hold_control.v ====
// pad control across reset, sleep and deep sleep, with fixed function overrides
`timescale 1ns/100ps
`default_nettype none
`include "pad_sleep_hold_map.vh"

module pad_sleep_hold_control
#(
  parameter N_GPIO = 121,
  parameter N_FIXED = 4,
  parameter [N_GPIO-1:0] PULL_UP_MASK = {N_GPIO{1'b1}},
  parameter [N_GPIO-1:0] PULL_DOWN_MASK = {N_GPIO{1'b0}},
  parameter [N_GPIO-1:0] STATIC_MEM_MASK = {N_GPIO{1'b0}},
  parameter [N_GPIO-1:0] CARD_CTRL_MASK = {N_GPIO{1'b0}},
  parameter [N_GPIO-1:0] TIMER_STOP_MASK = {N_GPIO{1'b0}}
)
(
  input wire CLK,
  input wire SRST,
  input wire RESET_IN_N,
  input wire SLEEP,
  input wire DEEP_SLEEP,
  input wire [N_GPIO-1:0] PM_OVERRIDE,
  input wire [N_GPIO-1:0] FUNC_DIR,
  input wire [N_GPIO-1:0] FUNC_OUT,
  input wire [N_GPIO-1:0] GPIO_PIN_IN,
  input wire [N_GPIO-1:0] SLEEP_PIN_VALUE,
  input wire READ_DISABLE_HOLD_CLR,
  input wire PERIPHERAL_HOLD_CLR,
  input wire STATIC_MEM_FLOAT,
  input wire CARD_CTRL_FLOAT,
  input wire OS_TIMER_ACTIVE,
  input wire SMARTCARD_SEL_A,
  input wire SMARTCARD_SEL_B,
  input wire SMARTCARD_ENABLE,
  input wire PROC_CLK_OUT_ENABLE,
  input wire TIMER_CLK_OUT_ENABLE,
  input wire PROC_CLOCK_OUTPUT,
  input wire TIMER_CLOCK_OUTPUT,
  input wire [N_FIXED-1:0] FIXED_FUNC_DIR,
  input wire [N_FIXED-1:0] FIXED_FUNC_OUT,
  input wire OSC_LINK_IN,
  output reg [N_GPIO-1:0] GPIO_OE,
  output reg [N_GPIO-1:0] GPIO_OUT,
  output reg [N_GPIO-1:0] GPIO_PULL_UP,
  output reg [N_GPIO-1:0] GPIO_PULL_DOWN,
  output reg [N_GPIO-1:0] GPIO_IN_ENABLE,
  output reg [N_GPIO-1:0] GPIO_IN_DATA,
  output reg [N_FIXED-1:0] FIXED_OE,
  output reg [N_FIXED-1:0] FIXED_OUT,
  output reg READ_DISABLE_HOLD,
  output reg PERIPHERAL_HOLD,
  output reg SYSTEM_ENABLE_OUT,
  output reg POWER_ENABLE_OUT,
  output reg INTERNAL_RESET,
  output reg OSC_LINK_OUT
);

  // -------------------------------------------------------------------------
  // sequencer states and counts
  // -------------------------------------------------------------------------
  localparam [3:0] ST_OFF = 4'h1;
  localparam [3:0] ST_SYS = 4'h2;
  localparam [3:0] ST_PWR = 4'h4;
  localparam [3:0] ST_RUN = 4'h8;
  localparam [31:0] SYS_CYC_FULL = `SYS_TO_PWR_CYC;
  localparam [31:0] PWR_CYC_FULL = `PWR_TO_RUN_CYC;
  localparam [7:0] SYS_CYC = SYS_CYC_FULL[7:0];
  localparam [7:0] PWR_CYC = PWR_CYC_FULL[7:0];

  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_sync_reg;
  reg [N_GPIO-1:0] pin_meta_reg;
  reg [N_GPIO-1:0] pin_sync_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg asleep_prev_reg;
  reg [N_GPIO-1:0] slp_dir_reg;
  reg [N_GPIO-1:0] slp_val_reg;
  wire pin_reset;
  wire asleep;
  wire deep;
  wire sleep_entry;
  wire hold_set;
  wire clk_ov;
  wire sc_ov;
  wire [N_GPIO-1:0] oe_next;
  wire [N_GPIO-1:0] out_next;
  wire [N_GPIO-1:0] pu_next;
  wire [N_GPIO-1:0] pd_next;
  wire [N_GPIO-1:0] ie_next;
  wire [N_FIXED-1:0] fixed_oe_next;
  wire [N_GPIO-1:0] cap_dir;
  wire [N_GPIO-1:0] cap_val;

  // -------------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------------
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      rst_meta_reg <= `SYNC_RESET_VAL;
      rst_sync_reg <= `SYNC_RESET_VAL;
      pin_meta_reg <= {N_GPIO{1'b0}};
      pin_sync_reg <= {N_GPIO{1'b0}};
    end
    else
    begin
      rst_meta_reg <= RESET_IN_N;
      rst_sync_reg <= rst_meta_reg;
      pin_meta_reg <= GPIO_PIN_IN;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign pin_reset = ~rst_sync_reg;

  // -------------------------------------------------------------------------
  // power-up sequencer
  // -------------------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_OFF:
      begin
        state_next = ST_SYS;
        cnt_next = 8'h00;
      end
      ST_SYS:
      begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg >= SYS_CYC - 8'h01)
        begin
          state_next = ST_PWR;
          cnt_next = 8'h00;
        end
      end
      ST_PWR:
      begin
        if (pin_reset)
          cnt_next = 8'h00;
        else if (cnt_reg < PWR_CYC - 8'h01)
          cnt_next = cnt_reg + 8'h01;
        else
          state_next = ST_RUN;
      end
      ST_RUN:
      begin
        // warm reset keeps supplies up and only reasserts internal reset
        if (pin_reset)
        begin
          state_next = ST_PWR;
          cnt_next = 8'h00;
        end
      end
      default:
      begin
        state_next = ST_OFF;
        cnt_next = 8'h00;
      end
    endcase
  end

  always @(posedge CLK)
  begin
    if (SRST)
    begin
      state_reg <= ST_OFF;
      cnt_reg <= 8'h00;
      SYSTEM_ENABLE_OUT <= 1'b0;
      POWER_ENABLE_OUT <= 1'b0;
      INTERNAL_RESET <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      SYSTEM_ENABLE_OUT <= (state_next != ST_OFF);
      POWER_ENABLE_OUT <= (state_next == ST_PWR) || (state_next == ST_RUN);
      INTERNAL_RESET <= (state_next != ST_RUN);
    end
  end

  // -------------------------------------------------------------------------
  // hold bits and sleep capture
  // -------------------------------------------------------------------------
  assign asleep = SLEEP & ~DEEP_SLEEP;
  assign deep = DEEP_SLEEP | INTERNAL_RESET;
  assign sleep_entry = (SLEEP | DEEP_SLEEP) & ~asleep_prev_reg;
  assign hold_set = INTERNAL_RESET | sleep_entry;

  always @(posedge CLK)
  begin
    if (SRST)
    begin
      READ_DISABLE_HOLD <= `HOLD_RESET_VAL;
      PERIPHERAL_HOLD <= `HOLD_RESET_VAL;
      asleep_prev_reg <= 1'b0;
      slp_dir_reg <= {N_GPIO{1'b0}};
      slp_val_reg <= {N_GPIO{1'b0}};
    end
    else
    begin
      asleep_prev_reg <= SLEEP | DEEP_SLEEP;
      // setting wins over a clear landing in the same cycle
      if (hold_set)
        READ_DISABLE_HOLD <= 1'b1;
      else if (READ_DISABLE_HOLD_CLR)
        READ_DISABLE_HOLD <= 1'b0;
      if (hold_set)
        PERIPHERAL_HOLD <= 1'b1;
      else if (PERIPHERAL_HOLD_CLR)
        PERIPHERAL_HOLD <= 1'b0;
      if (sleep_entry)
      begin
        slp_dir_reg <= FUNC_DIR;
        slp_val_reg <= SLEEP_PIN_VALUE;
      end
    end
  end

  // -------------------------------------------------------------------------
  // per-pin control
  // -------------------------------------------------------------------------
  assign clk_ov = PROC_CLK_OUT_ENABLE | TIMER_CLK_OUT_ENABLE;
  assign sc_ov = SMARTCARD_SEL_A | SMARTCARD_SEL_B;
  // the entry cycle uses live values, since the capture lands one edge later
  assign cap_dir = sleep_entry ? FUNC_DIR : slp_dir_reg;
  assign cap_val = sleep_entry ? SLEEP_PIN_VALUE : slp_val_reg;

  genvar i;
  generate
    for (i = 0; i < N_GPIO; i = i + 1)
    begin : g_pin
      wire is_clk_a;
      wire is_clk_b;
      wire is_sc;
      wire forced;
      wire fn_out;
      wire lowp;
      wire flt;
      assign is_clk_a = clk_ov && (i == `PROC_CLK_PIN);
      assign is_clk_b = clk_ov && (i == `TIMER_CLK_PIN);
      assign is_sc = sc_ov && ((i == `SMARTCARD_PIN_A) || (i == `SMARTCARD_PIN_B));
      assign forced = is_clk_a | is_clk_b | is_sc;
      // clocks are resampled at the block rate, so they only suit slow clocks
      assign fn_out = is_clk_a ? PROC_CLOCK_OUTPUT :
        is_clk_b ? TIMER_CLOCK_OUTPUT :
        is_sc ? SMARTCARD_ENABLE :
        FUNC_OUT[i];
      // after wake the captured sleep state stays on until peripheral hold clears
      assign lowp = asleep | PERIPHERAL_HOLD;
      assign flt = asleep & ((STATIC_MEM_MASK[i] & STATIC_MEM_FLOAT) |
        (CARD_CTRL_MASK[i] & CARD_CTRL_FLOAT) |
        (TIMER_STOP_MASK[i] & OS_TIMER_ACTIVE));
      assign oe_next[i] = PM_OVERRIDE[i] ? FUNC_DIR[i] :
        deep ? 1'b0 :
        lowp ? (cap_dir[i] & ~flt) :
        (FUNC_DIR[i] | forced);
      assign out_next[i] = PM_OVERRIDE[i] ? FUNC_OUT[i] :
        lowp ? cap_val[i] : fn_out;
      assign pu_next[i] = ~PM_OVERRIDE[i] & READ_DISABLE_HOLD & PULL_UP_MASK[i];
      assign pd_next[i] = ~PM_OVERRIDE[i] & READ_DISABLE_HOLD & PULL_DOWN_MASK[i];
      assign ie_next[i] = PM_OVERRIDE[i] | ~READ_DISABLE_HOLD;
    end
  endgenerate

  // pins with no sleep value just follow static-memory float
  assign fixed_oe_next = FIXED_FUNC_DIR & {N_FIXED{~(asleep & STATIC_MEM_FLOAT)}};

  // -------------------------------------------------------------------------
  // output registers
  // -------------------------------------------------------------------------
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      GPIO_OE <= {N_GPIO{1'b0}};
      GPIO_OUT <= {N_GPIO{1'b0}};
      GPIO_PULL_UP <= PULL_UP_MASK;
      GPIO_PULL_DOWN <= PULL_DOWN_MASK;
      GPIO_IN_ENABLE <= {N_GPIO{1'b0}};
      GPIO_IN_DATA <= {N_GPIO{1'b0}};
      FIXED_OE <= {N_FIXED{1'b0}};
      FIXED_OUT <= {N_FIXED{1'b0}};
    end
    else
    begin
      GPIO_OE <= oe_next;
      GPIO_OUT <= out_next;
      GPIO_PULL_UP <= pu_next;
      GPIO_PULL_DOWN <= pd_next;
      GPIO_IN_ENABLE <= ie_next;
      GPIO_IN_DATA <= pin_sync_reg & ie_next;
      FIXED_OE <= fixed_oe_next;
      FIXED_OUT <= FIXED_FUNC_OUT;
    end
  end

  // oscillator path deliberately has no reset and no sleep term
  always @(posedge CLK)
  begin
    OSC_LINK_OUT <= OSC_LINK_IN;
  end

endmodule // pad_sleep_hold_control
`default_nettype wire

// ==== pad_sleep_hold_control_chk.sv ====
// assertion checker for the pad sleep and hold controller
`timescale 1ns/100ps
`default_nettype none
module pad_sleep_hold_control_chk
#(
  parameter N_GPIO = 121,
  parameter [N_GPIO-1:0] PULL_UP_MASK = {N_GPIO{1'b1}},
  parameter [N_GPIO-1:0] PULL_DOWN_MASK = {N_GPIO{1'b0}}
)
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SLEEP,
  input wire logic DEEP_SLEEP,
  input wire logic [N_GPIO-1:0] PM_OVERRIDE,
  input wire logic READ_DISABLE_HOLD_CLR,
  input wire logic PERIPHERAL_HOLD_CLR,
  input wire logic SMARTCARD_SEL_A,
  input wire logic SMARTCARD_SEL_B,
  input wire logic SMARTCARD_ENABLE,
  input wire logic PROC_CLK_OUT_ENABLE,
  input wire logic TIMER_CLK_OUT_ENABLE,
  input wire logic PROC_CLOCK_OUTPUT,
  input wire logic [N_GPIO-1:0] GPIO_OE,
  input wire logic [N_GPIO-1:0] GPIO_OUT,
  input wire logic [N_GPIO-1:0] GPIO_PULL_UP,
  input wire logic [N_GPIO-1:0] GPIO_PULL_DOWN,
  input wire logic [N_GPIO-1:0] GPIO_IN_ENABLE,
  input wire logic READ_DISABLE_HOLD,
  input wire logic PERIPHERAL_HOLD,
  input wire logic SYSTEM_ENABLE_OUT,
  input wire logic POWER_ENABLE_OUT,
  input wire logic INTERNAL_RESET
);
  // normal running: overrides only apply outside reset, sleep and hold
  wire logic run = !INTERNAL_RESET && !SLEEP && !DEEP_SLEEP && !PERIPHERAL_HOLD;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  chk_pwr_after_sys: assert property ($rose(POWER_ENABLE_OUT) |->
    $past(SYSTEM_ENABLE_OUT) && INTERNAL_RESET) else $error("power enable out of order");
  chk_clk_out_pin: assert property ((PROC_CLK_OUT_ENABLE || TIMER_CLK_OUT_ENABLE)
    && run && !PM_OVERRIDE[9] |=> GPIO_OE[9] && GPIO_OUT[9] == $past(PROC_CLOCK_OUTPUT))
    else $error("clock output not on pin 9");
  chk_smartcard_force: assert property ((SMARTCARD_SEL_A || SMARTCARD_SEL_B)
    && run && !PM_OVERRIDE[114] |=> GPIO_OUT[114] == $past(SMARTCARD_ENABLE))
    else $error("smart-card enable not forced");
  chk_override_pulls: assert property (PM_OVERRIDE[0] |=> !GPIO_PULL_UP[0]
    && !GPIO_PULL_DOWN[0] && GPIO_IN_ENABLE[0]) else $error("override kept pulls");
  chk_hold_pulls: assert property (READ_DISABLE_HOLD && !READ_DISABLE_HOLD_CLR
    && PM_OVERRIDE == 0 |=> GPIO_PULL_UP == PULL_UP_MASK && GPIO_PULL_DOWN == PULL_DOWN_MASK
    && GPIO_IN_ENABLE == 0) else $error("held pin defaults wrong");
  chk_deep_no_drive: assert property (DEEP_SLEEP && PM_OVERRIDE == 0 |=>
    GPIO_OE == 0) else $error("pin driven in deep sleep");
  chk_hold_set_sleep: assert property ($rose(SLEEP || DEEP_SLEEP) |=>
    READ_DISABLE_HOLD && PERIPHERAL_HOLD) else $error("holds not set on sleep entry");
  chk_hold_zero_write: assert property (PERIPHERAL_HOLD && !PERIPHERAL_HOLD_CLR |=>
    PERIPHERAL_HOLD) else $error("peripheral hold dropped by itself");

  // main scenarios reached
  cover property ($rose(POWER_ENABLE_OUT));
  cover property ($fell(PERIPHERAL_HOLD));
  cover property (SLEEP && GPIO_OE != 0);
endmodule // pad_sleep_hold_control_chk
`default_nettype wire

// ==== pad_sleep_hold_control_tb.sv ====
// self-checking bench for the pad sleep and hold controller
`timescale 1ns/100ps
`default_nettype none
`include "pad_sleep_hold_map.vh"
module pad_sleep_hold_control_tb;
  localparam N = 121;
  logic CLK = 0, SRST = 1, RESET_IN_N = 1, SLEEP = 0, DEEP_SLEEP = 0;
  logic [N-1:0] PM_OVERRIDE = 121'h0, FUNC_DIR = ~121'h0, FUNC_OUT = 121'h0;
  logic [N-1:0] GPIO_PIN_IN = 121'h5, SLEEP_PIN_VALUE = 121'h0;
  logic READ_DISABLE_HOLD_CLR = 0, PERIPHERAL_HOLD_CLR = 0, STATIC_MEM_FLOAT = 0;
  logic CARD_CTRL_FLOAT = 0, OS_TIMER_ACTIVE = 0, SMARTCARD_SEL_A = 0, SMARTCARD_SEL_B = 0;
  logic SMARTCARD_ENABLE = 0, PROC_CLK_OUT_ENABLE = 0, TIMER_CLK_OUT_ENABLE = 0;
  logic PROC_CLOCK_OUTPUT = 0, TIMER_CLOCK_OUTPUT = 0, OSC_LINK_IN = 0;
  logic [3:0] FIXED_FUNC_DIR = 4'hF, FIXED_FUNC_OUT = 4'h5;
  wire logic [N-1:0] GPIO_OE, GPIO_OUT, GPIO_PULL_UP, GPIO_PULL_DOWN, GPIO_IN_ENABLE;
  wire logic [N-1:0] GPIO_IN_DATA;
  wire logic [3:0] FIXED_OE, FIXED_OUT;
  wire logic READ_DISABLE_HOLD, PERIPHERAL_HOLD, SYSTEM_ENABLE_OUT, POWER_ENABLE_OUT;
  wire logic INTERNAL_RESET, OSC_LINK_OUT;
  int n_errors = 0, compares = 0, cycles = 0, i;
  // sel_a sel_b pclk_en tclk_en | sc_en pclk tclk fout | pin 9 10 114 115
  logic [11:0] rows [6] = '{12'h01F, 12'h883, 12'h41C, 12'h248, 12'h137, 12'h000};

  pad_sleep_hold_control #(.PULL_UP_MASK(121'h5), .PULL_DOWN_MASK(121'hA),
    .STATIC_MEM_MASK(121'h10), .CARD_CTRL_MASK(121'h20), .TIMER_STOP_MASK(121'h2)) uut (
    .CLK(CLK), .SRST(SRST), .RESET_IN_N(RESET_IN_N), .SLEEP(SLEEP), .DEEP_SLEEP(DEEP_SLEEP),
    .PM_OVERRIDE(PM_OVERRIDE), .FUNC_DIR(FUNC_DIR), .FUNC_OUT(FUNC_OUT),
    .GPIO_PIN_IN(GPIO_PIN_IN), .SLEEP_PIN_VALUE(SLEEP_PIN_VALUE),
    .READ_DISABLE_HOLD_CLR(READ_DISABLE_HOLD_CLR), .PERIPHERAL_HOLD_CLR(PERIPHERAL_HOLD_CLR),
    .STATIC_MEM_FLOAT(STATIC_MEM_FLOAT), .CARD_CTRL_FLOAT(CARD_CTRL_FLOAT),
    .OS_TIMER_ACTIVE(OS_TIMER_ACTIVE), .SMARTCARD_SEL_A(SMARTCARD_SEL_A),
    .SMARTCARD_SEL_B(SMARTCARD_SEL_B), .SMARTCARD_ENABLE(SMARTCARD_ENABLE),
    .PROC_CLK_OUT_ENABLE(PROC_CLK_OUT_ENABLE), .TIMER_CLK_OUT_ENABLE(TIMER_CLK_OUT_ENABLE),
    .PROC_CLOCK_OUTPUT(PROC_CLOCK_OUTPUT), .TIMER_CLOCK_OUTPUT(TIMER_CLOCK_OUTPUT),
    .FIXED_FUNC_DIR(FIXED_FUNC_DIR), .FIXED_FUNC_OUT(FIXED_FUNC_OUT),
    .OSC_LINK_IN(OSC_LINK_IN), .GPIO_OE(GPIO_OE), .GPIO_OUT(GPIO_OUT),
    .GPIO_PULL_UP(GPIO_PULL_UP), .GPIO_PULL_DOWN(GPIO_PULL_DOWN),
    .GPIO_IN_ENABLE(GPIO_IN_ENABLE), .GPIO_IN_DATA(GPIO_IN_DATA), .FIXED_OE(FIXED_OE),
    .FIXED_OUT(FIXED_OUT), .READ_DISABLE_HOLD(READ_DISABLE_HOLD),
    .PERIPHERAL_HOLD(PERIPHERAL_HOLD), .SYSTEM_ENABLE_OUT(SYSTEM_ENABLE_OUT),
    .POWER_ENABLE_OUT(POWER_ENABLE_OUT), .INTERNAL_RESET(INTERNAL_RESET),
    .OSC_LINK_OUT(OSC_LINK_OUT));

  always #25 CLK = ~CLK;
  // a hang is cut short well past the roughly 120 cycles the run needs
  always @(posedge CLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic end_sim();
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    cyc(8);
    SRST <= 0;
    chk(GPIO_OE, 0);
    chk({GPIO_PULL_UP, GPIO_PULL_DOWN}, {121'h5, 121'hA});
    chk({GPIO_IN_ENABLE, READ_DISABLE_HOLD, PERIPHERAL_HOLD}, 3);
    for (i = 0; i < 200 && INTERNAL_RESET !== 1'b0; i++)
      cyc(1);
    chk({SYSTEM_ENABLE_OUT, POWER_ENABLE_OUT, INTERNAL_RESET}, 3'h6);
    chk(i, 2 + `SYS_TO_PWR_CYC + `PWR_TO_RUN_CYC);
    cyc(4);
    chk(PERIPHERAL_HOLD, 1);
    READ_DISABLE_HOLD_CLR <= 1;
    PERIPHERAL_HOLD_CLR <= 1;
    cyc(1);
    READ_DISABLE_HOLD_CLR <= 0;
    PERIPHERAL_HOLD_CLR <= 0;
    cyc(5);
    chk({READ_DISABLE_HOLD, PERIPHERAL_HOLD, GPIO_PULL_UP | GPIO_PULL_DOWN}, 0);
    chk({GPIO_IN_ENABLE, GPIO_IN_DATA[2:0]}, {~121'h0, 3'h5});
    chk(FIXED_OUT, 4'h5);
    foreach (rows[k])
    begin
      {SMARTCARD_SEL_A, SMARTCARD_SEL_B, PROC_CLK_OUT_ENABLE, TIMER_CLK_OUT_ENABLE,
        SMARTCARD_ENABLE, PROC_CLOCK_OUTPUT, TIMER_CLOCK_OUTPUT} <= rows[k][11:5];
      FUNC_OUT <= {N{rows[k][4]}};
      cyc(3);
      chk({GPIO_OUT[9], GPIO_OUT[10], GPIO_OUT[114], GPIO_OUT[115]}, rows[k][3:0]);
    end
    // pin 1 timer stop, pin 2 input, pin 4 static-memory, pin 5 card control
    FUNC_DIR <= 121'h33;
    SLEEP_PIN_VALUE <= 121'h31;
    STATIC_MEM_FLOAT <= 1;
    cyc(1);
    SLEEP <= 1;
    cyc(1);
    SLEEP_PIN_VALUE <= 121'h0;
    cyc(3);
    chk({GPIO_OE[5:0], GPIO_OUT[1:0]}, {6'h23, 2'h1});
    chk(FIXED_OE, 4'h0);
    {STATIC_MEM_FLOAT, CARD_CTRL_FLOAT, OS_TIMER_ACTIVE} <= 3'h3;
    cyc(3);
    chk({GPIO_OE[5:0], FIXED_OE}, {6'h11, 4'hF});
    SLEEP <= 0;
    cyc(3);
    chk({READ_DISABLE_HOLD, PERIPHERAL_HOLD, GPIO_IN_ENABLE[2]}, 3'h6);
    chk({GPIO_OE[0], GPIO_OUT[0]}, 2'h3);
    PM_OVERRIDE <= 121'h1;
    cyc(3);
    chk({GPIO_PULL_UP[0], GPIO_IN_ENABLE[0], GPIO_PULL_UP[2], GPIO_OUT[0]}, 4'h6);
    PM_OVERRIDE <= 121'h0;
    PERIPHERAL_HOLD_CLR <= 1;
    cyc(1);
    PERIPHERAL_HOLD_CLR <= 0;
    FUNC_OUT <= 121'h2;
    cyc(3);
    chk({PERIPHERAL_HOLD, GPIO_OUT[1:0]}, 3'h2);
    DEEP_SLEEP <= 1;
    PERIPHERAL_HOLD_CLR <= 1;
    cyc(1);
    PERIPHERAL_HOLD_CLR <= 0;
    cyc(2);
    chk({GPIO_OE, PERIPHERAL_HOLD}, 1);
    DEEP_SLEEP <= 0;
    OSC_LINK_IN <= 1;
    SRST <= 1;
    cyc(3);
    chk({OSC_LINK_OUT, POWER_ENABLE_OUT, READ_DISABLE_HOLD}, 3'h5);
    end_sim();
  end
endmodule // pad_sleep_hold_control_tb

bind pad_sleep_hold_control pad_sleep_hold_control_chk #(.N_GPIO(N_GPIO),
  .PULL_UP_MASK(PULL_UP_MASK), .PULL_DOWN_MASK(PULL_DOWN_MASK)) chk_i (
  .CLK(CLK), .SRST(SRST), .SLEEP(SLEEP), .DEEP_SLEEP(DEEP_SLEEP), .PM_OVERRIDE(PM_OVERRIDE),
  .READ_DISABLE_HOLD_CLR(READ_DISABLE_HOLD_CLR), .PERIPHERAL_HOLD_CLR(PERIPHERAL_HOLD_CLR),
  .SMARTCARD_SEL_A(SMARTCARD_SEL_A), .SMARTCARD_SEL_B(SMARTCARD_SEL_B),
  .SMARTCARD_ENABLE(SMARTCARD_ENABLE), .PROC_CLK_OUT_ENABLE(PROC_CLK_OUT_ENABLE),
  .TIMER_CLK_OUT_ENABLE(TIMER_CLK_OUT_ENABLE), .PROC_CLOCK_OUTPUT(PROC_CLOCK_OUTPUT),
  .GPIO_OE(GPIO_OE), .GPIO_OUT(GPIO_OUT), .GPIO_PULL_UP(GPIO_PULL_UP),
  .GPIO_PULL_DOWN(GPIO_PULL_DOWN), .GPIO_IN_ENABLE(GPIO_IN_ENABLE),
  .READ_DISABLE_HOLD(READ_DISABLE_HOLD), .PERIPHERAL_HOLD(PERIPHERAL_HOLD),
  .SYSTEM_ENABLE_OUT(SYSTEM_ENABLE_OUT), .POWER_ENABLE_OUT(POWER_ENABLE_OUT),
  .INTERNAL_RESET(INTERNAL_RESET));
`default_nettype wire
